/* bench/cief_bank_props.sv */
`timescale 1ns/1ps
module cief_bank_props
	import cief_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	input wire logic [NUM_EVENTS-1:0] eventPulse,
	input wire logic moduleOn,
	input wire logic intReq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_rsv; regRd |=> !(regRdData & 32'h07F0_07F0); endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
	property p_en; regWr && regAddr == 0 ##1 !regWr ##1 regRd &&
		regAddr == 0 |=>
		regRdData[31:16] == ($past(regWrData[31:16], 3) & 16'hF80F);
	endproperty
	a_en: assert property (p_en) else $error("en");
	property p_ivr; eventPulse[8] ##1 !regWr ##1 regRd && regAddr == 0
		|=> regRdData[15]; endproperty
	a_ivr: assert property (p_ivr) else $error("ivr");
	property p_hold; !regWr && !eventPulse |=> $stable(intReq); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	// Clearing every enable must silence the request in the next cycle
	property p_en_gate; regWr && regAddr == OFS_ENABLE &&
		regWrData == 32'h0000_0000 |=> !intReq; endproperty
	a_en_gate: assert property (p_en_gate) else $error("en gate");
	property p_on; regWr && regAddr == OFS_CONTROL |=>
		moduleOn == $past(regWrData[MODULE_ON_BIT]); endproperty
	a_on: assert property (p_on) else $error("module on");
	property p_rd_idle; !regRd |=> regRdData == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rd idle");
endmodule : cief_bank_props
bind cief_bank cief_bank_props i_cief_bank_props (
	.clk(clk),
	.sys_rst(sys_rst),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData(regRdData),
	.eventPulse(eventPulse),
	.moduleOn(moduleOn),
	.intReq(intReq)
);

/* bench/cief_bank_tb.sv */
`timescale 1ns/1ps
module cief_bank_tb
	import cief_pkg::*;
;
	logic clk = 0;
	logic sys_rst = 1;
	logic [7:0] regAddr = 0;
	logic [31:0] regWrData = 0;
	logic regWr = 0;
	logic regRd = 0;
	logic [8:0] eventPulse = 0;
	logic [31:0] regRdData, flg;
	logic moduleOn, intReq;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	cief_bank i_cief_bank (
		.clk(clk),
		.sys_rst(sys_rst),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWr(regWr),
		.regRd(regRd),
		.regRdData(regRdData),
		.eventPulse(eventPulse),
		.moduleOn(moduleOn),
		.intReq(intReq)
	);
	always #2.5 clk = ~clk;
	task automatic end_sim;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	always @(posedge clk) if (++cyc == 400) begin
		err_count++;
		end_sim();
	end
	task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic q);
		@(posedge clk);
		regWr <= w;
		regRd <= !w;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 0;
		regRd <= 0;
		@(negedge clk);
		cmp_count++;
		if ({intReq, w ? d : regRdData} !== {q, d}) begin
			err_count++;
			$display("CHECK FAILED %0t register or intReq mismatch", $time);
		end
	endtask : acc
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t moduleOn mismatch", $time);
		end
	endtask : chk
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		acc(0, 0, 0, 0);
		chk({31'h0000_0000, moduleOn}, 32'h0000_0000);
		acc(1, 0, '1, 0);
		acc(0, 0, 32'hF80F_0000, 0);
		$display("T1 done");
		flg = 32'hF80F_0000;
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			eventPulse <= 9'h001 << i;
			@(posedge clk);
			eventPulse <= 0;
			flg[i < 4 ? i : i + 7] = 1;
			acc(0, 0, flg, 1);
		end
		acc(1, 8'h0C, 0, 0);
		acc(1, 8'h08, '1, 0);
		acc(0, 8'h04, 32'h1000, 0);
		acc(1, 8'h0C, 32'h1000, 1);
		acc(1, 8'h10, 32'h8000, 0);
		chk({31'h0000_0000, moduleOn}, 32'h0000_0001);
		acc(0, 8'h14, 0, 0);
		$display("T2 done");
		acc(0, 8'h0C, 32'h0000_1000, 0);
		acc(0, 8'h10, 32'h0000_8000, 0);
		@(posedge clk);
		eventPulse <= 9'h120;
		@(posedge clk);
		eventPulse <= 0;
		acc(0, 8'h04, 32'h0000_9000, 1);
		// Zeros in the main register clear every flag but system error
		acc(1, 0, 32'h1000_0000, 1);
		acc(0, 0, 32'h1000_1000, 1);
		acc(1, 8'h10, 32'h0000_8000, 1);
		acc(1, 8'h10, 0, 1);
		chk({31'h0000_0000, moduleOn}, 32'h0000_0000);
		acc(1, 8'h10, 32'h0000_8000, 0);
		acc(1, 0, 32'h07F0_07F0, 0);
		acc(0, 0, 0, 0);
		$display("T3 done");
		@(posedge clk);
		eventPulse <= 9'h1FF;
		@(posedge clk);
		eventPulse <= 0;
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		acc(0, 0, 0, 0);
		acc(0, 8'h10, 0, 0);
		chk({31'h0000_0000, moduleOn}, 32'h0000_0000);
		$display("T4 done");
		end_sim();
	end
endmodule : cief_bank_tb

/* hw/cief_bank.sv */
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// What this block does
// RQ1: Nine enables at bits 31..27, 19..16.
// RQ2: Invalid-message flag bit 15 set on event.
// RQ3: System-error flag cleared only by module off-on.
// RQ4: Unimplemented bits read zero, writes ignored.
// RQ5: Enables 30..27: wakeup, bus error, syserr, overflow.
// RQ6: Enables 19..16: mode, timestamp, rx, tx buffer.
// RQ7: Request while enabled flag set; reset zero.
module cief_bank
	import cief_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// Event pulses from the protocol engine, one bit per event index
	input wire logic [NUM_EVENTS-1:0] eventPulse,
	// Module state and interrupt
	output logic moduleOn,
	output logic intReq
);

	cief_state_s st_r;
	cief_state_s st_nxt;
	logic [NUM_EVENTS-1:0] flags;
	logic [NUM_EVENTS-1:0] clrEv;
	logic [31:0] flagWord;
	logic [31:0] enableWord;
	logic wrIntReg;
	logic wrClear;
	logic onRise;

	assign wrIntReg = regWr && (regAddr == OFS_INT_REG);
	assign wrClear = regWr && (regAddr == OFS_CLEAR);
	// Off-to-on edge of the module enable
	assign onRise = regWr && (regAddr == OFS_CONTROL) &&
		regWrData[MODULE_ON_BIT] && !st_r.moduleOn;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++) begin : gFlag
			if (gi == EV_SYSTEM_ERROR) begin : gSys
				// Writes to the main and clear registers cannot touch this flag; only an off-to-on control write clears it
				assign clrEv[gi] = onRise; // RQ3
			end else begin : gSw
				// Writing 0 into the main register, or 1 into clear
				assign clrEv[gi] =
					(wrIntReg && !regWrData[flag_pos(gi)]) ||
					(wrClear && regWrData[flag_pos(gi)]);
			end
			cief_flag_cell uCell (
				.clk(clk),
				.sys_rst(sys_rst),
				.setEv(eventPulse[gi]), // RQ2
				.clrEv(clrEv[gi]),
				.flag(flags[gi])
			);
		end
	endgenerate

	// Place flags and enables at their bit positions; the rest stays 0
	always_comb begin
		flagWord = RESET_WORD;
		enableWord = RESET_WORD;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			flagWord[flag_pos(i)] = flags[i]; // RQ2
			enableWord[flag_pos(i) + ENABLE_SHIFT] = st_r.enable[i]; // RQ1 RQ5 RQ6
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdData = RESET_WORD;
		if (regWr) begin
			case (regAddr)
				OFS_INT_REG: begin
					// Only implemented enable positions are stored
					for (int i = 0; i < NUM_EVENTS; i++) begin
						st_nxt.enable[i] =
							regWrData[flag_pos(i) + ENABLE_SHIFT]; // RQ1 RQ4 RQ5 RQ6
					end
				end
				OFS_ENABLE: begin
					for (int i = 0; i < NUM_EVENTS; i++) begin
						st_nxt.enable[i] = regWrData[flag_pos(i)];
					end
				end
				OFS_CONTROL: begin
					st_nxt.moduleOn = regWrData[MODULE_ON_BIT];
				end
				default: begin
				end
			endcase
		end
		if (regRd) begin
			case (regAddr)
				OFS_INT_REG: st_nxt.rdData = enableWord | flagWord; // RQ4
				OFS_STATUS: st_nxt.rdData = flagWord;
				OFS_ENABLE: st_nxt.rdData = enableWord >> ENABLE_SHIFT;
				OFS_CONTROL: begin
					st_nxt.rdData[MODULE_ON_BIT] = st_r.moduleOn;
				end
				// Clear register is write-only and reads zero
				default: st_nxt.rdData = RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r.enable <= RESET_ENABLE; // RQ7
			st_r.moduleOn <= RESET_ON;
			st_r.rdData <= RESET_WORD;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdData = st_r.rdData;
	assign moduleOn = st_r.moduleOn;
	// Level request straight from registered flags and enables
	assign intReq = |(flags & st_r.enable); // RQ7

endmodule : cief_bank

/* hw/cief_flag_cell.sv */
`timescale 1ns/1ps
module cief_flag_cell
	import cief_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Set and clear requests
	input wire logic setEv,
	input wire logic clrEv,
	// Sticky flag
	output logic flag
);

	cief_cell_s st_r;
	cief_cell_s st_nxt;

	// Set beats clear so an event in the clearing cycle is kept
	always_comb begin
		st_nxt = st_r;
		if (setEv) begin
			st_nxt.flag = 1'h1;
		end else if (clrEv) begin
			st_nxt.flag = 1'h0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r.flag <= RESET_FLAG;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;

endmodule : cief_flag_cell

/* hw/cief_pkg.sv */
package cief_pkg;

	// Register byte offsets on the plain register port
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_INT_REG = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CLEAR = 8'h08;
	localparam logic [7:0] OFS_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_CONTROL = 8'h10;

	// Event indices, lowest flag position first
	localparam int NUM_EVENTS = 9;
	localparam int EV_TX_BUFFER = 0;
	localparam int EV_RX_BUFFER = 1;
	localparam int EV_TIMESTAMP_TIMER = 2;
	localparam int EV_MODE_CHANGE = 3;
	localparam int EV_RX_OVERFLOW = 4;
	localparam int EV_SYSTEM_ERROR = 5;
	localparam int EV_BUS_ERROR = 6;
	localparam int EV_BUS_WAKEUP = 7;
	localparam int EV_INVALID_MSG = 8;

	// Field layout: flags at 3..0 and 15..11, enables sixteen higher
	localparam int LOW_FLAG_COUNT = 4;
	localparam int HIGH_FLAG_GAP = 7;
	localparam int ENABLE_SHIFT = 16;
	localparam int MODULE_ON_BIT = 15;

	// Reset values
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [8:0] RESET_ENABLE = 9'h000;
	localparam logic RESET_ON = 1'h0;
	localparam logic RESET_FLAG = 1'h0;

	typedef struct packed {
		logic [8:0] enable;
		logic moduleOn;
		logic [31:0] rdData;
	} cief_state_s;

	typedef struct packed {
		logic flag;
	} cief_cell_s;

	function automatic int flag_pos(input int idx);
		return (idx < LOW_FLAG_COUNT) ? idx : idx + HIGH_FLAG_GAP;
	endfunction : flag_pos

endpackage : cief_pkg
